// File: hw/ecr_flash_dev.sv
// Purpose: flash-side interpreter for the ECC register commands
// Assumes: SPI mode 0; pins sampled by the system clock
// Notes: one ECC register per die; reads use the selected die
// Overview of operation
// - register write needs prior write unlock
// - host sends write opcode then one byte
// - write only if select rises right after bit 16
// - write takes effect at select rise, no busy
// - read opcode shifts register out on output
// - read returns previously selected die only
// - clear opcode zeroes bits six to one
// - bits six to one stay set until cleared
// - input bits sampled on serial clock rise
`timescale 1ns/100ps
module ecr_flash_dev
    import ecr_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    ecr_link_if.dev link,
    input wire logic i_sel_valid,
    input wire logic [DIE_W-1:0] i_sel_die,
    input wire logic i_evt_valid,
    input wire logic [DIE_W-1:0] i_evt_die,
    input wire logic [STICKY_HI:STICKY_LO] i_evt_bits,
    output logic [DIE_W-1:0] o_sel_die,
    output logic o_write_latch,
    output logic [ECC_W-1:0] o_ecc_reg
);
    // =========================================
    // Command states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OPCODE = 4'b0010,
        ST_DATA = 4'b0100,
        ST_READ = 4'b1000
    } ecr_dev_state_t;

    ecr_dev_state_t state;
    ecr_dev_state_t next_state;

    // =========================================
    // Pin synchronisers
    logic [2:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic cs_n_d;
    logic sck_d;

    ecr_sync #(.W(3), .INIT(3'h5)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async({link.cs_n, link.sck, link.si}),
        .o_sync(pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[0];

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cs_n_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            cs_n_d <= cs_n_s;
            sck_d <= sck_s;
        end
    end

    // =========================================
    // Edge decode
    wire sck_rise = ~cs_n_s & sck_s & ~sck_d;
    wire sck_fall = ~cs_n_s & ~sck_s & sck_d;
    wire cs_fall = cs_n_d & ~cs_n_s;
    wire cs_rise = ~cs_n_d & cs_n_s;

    // =========================================
    // Shift path
    logic [7:0] opcode;
    logic [7:0] data_in;
    logic [4:0] bit_cnt;
    logic [7:0] rd_sh;
    logic so_bit;
    logic write_latch;
    logic [DIE_W-1:0] sel_die;
    logic [ECC_W-1:0] ecc_reg [DIE_COUNT];

    wire [7:0] next_opcode = {opcode[6:0], si_s};
    wire opcode_done = sck_rise & (bit_cnt == BITS_OPCODE - 5'h01);
    wire [4:0] next_bit_cnt = (bit_cnt == 5'h1f) ? bit_cnt : bit_cnt + 5'h01;

    // Commands other than read act only at select rise on an exact byte boundary
    wire at_op_end = cs_rise & (bit_cnt == BITS_OPCODE);
    wire at_data_end = cs_rise & (bit_cnt == BITS_OP_DATA);
    wire do_unlock = at_op_end & (opcode == OP_WRITE_UNLOCK);
    wire do_clear = at_op_end & (opcode == OP_ECC_CLEAR);
    wire wr_seen = at_data_end & (opcode == OP_ECC_WRITE);
    wire do_write = wr_seen & write_latch;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cs_fall) begin
                    next_state = ST_OPCODE;
                end
            end
            ST_OPCODE: begin
                if (cs_n_s) begin
                    next_state = ST_IDLE;
                end else if (opcode_done) begin
                    if (next_opcode == OP_ECC_READ) begin
                        next_state = ST_READ;
                    end else begin
                        next_state = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (cs_n_s) begin
                    next_state = ST_IDLE;
                end
            end
            ST_READ: begin
                if (cs_n_s) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bit_cnt <= 5'h00;
            opcode <= 8'h00;
            data_in <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt <= 5'h00;
        end else if (sck_rise) begin
            bit_cnt <= next_bit_cnt;
            if (bit_cnt < BITS_OPCODE) begin
                opcode <= next_opcode;
            end else begin
                data_in <= {data_in[6:0], si_s};
            end
        end
    end

    // =========================================
    // Read-out: change on falling edge, mode 0
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rd_sh <= ECC_RESET;
            so_bit <= 1'b1;
        end else if (opcode_done) begin
            rd_sh <= ecc_reg[sel_die];
        end else if (sck_fall && state == ST_READ) begin
            so_bit <= rd_sh[7];
            // Rotating lets the host read the byte repeatedly
            rd_sh <= {rd_sh[6:0], rd_sh[7]};
        end
    end

    assign link.so_out = so_bit;
    assign link.so_oe_n = ~(state == ST_READ && !cs_n_s);

    // =========================================
    // Write latch and die selection
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            write_latch <= 1'b0;
        end else if (do_unlock) begin
            write_latch <= 1'b1;
        end else if (do_write) begin
            write_latch <= 1'b0;
        end
    end

    // The die is chosen by the array read path, not the link
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sel_die <= '0;
        end else if (i_sel_valid) begin
            sel_die <= i_sel_die;
        end
    end

    // =========================================
    // Per-die ECC registers
    genvar d;
    generate
        for (d = 0; d < DIE_COUNT; d++) begin : g_die
            logic [ECC_W-1:0] next_reg;
            wire is_sel = (sel_die == DIE_W'(d));
            wire hit_evt = i_evt_valid & (i_evt_die == DIE_W'(d));

            always_comb begin
                next_reg = ecc_reg[d];
                if (do_clear && is_sel) begin
                    next_reg = next_reg & ~STICKY_MASK;
                end
                if (do_write && is_sel) begin
                    // Write applies at once; sticky bits only set
                    next_reg = (data_in & ~STICKY_MASK)
                             | ((next_reg | data_in) & STICKY_MASK);
                end
                if (hit_evt) begin
                    // Event wins over a clear in the same cycle
                    next_reg[STICKY_HI:STICKY_LO] = next_reg[STICKY_HI:STICKY_LO]
                                                  | i_evt_bits;
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    ecc_reg[d] <= ECC_RESET;
                end else begin
                    ecc_reg[d] <= next_reg;
                end
            end
        end
    endgenerate

    // =========================================
    // User-side outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_sel_die <= '0;
            o_write_latch <= 1'b0;
            o_ecc_reg <= ECC_RESET;
        end else begin
            o_sel_die <= sel_die;
            o_write_latch <= write_latch;
            o_ecc_reg <= ecc_reg[sel_die];
        end
    end
endmodule : ecr_flash_dev

// File: hw/ecr_pkg.sv
// Purpose: shared constants for the ECC register command link
// Assumes: SPI mode 0, single lane, 40 MHz system clock
// Notes: host registers sit on classic Wishbone, 32-bit words
package ecr_pkg;
    // =========================================
    // Command opcodes
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_ECC_WRITE = 8'hb5;
    localparam logic [7:0] OP_ECC_READ = 8'hb3;
    localparam logic [7:0] OP_ECC_CLEAR = 8'hb6;
    // =========================================
    // ECC register layout
    localparam int ECC_W = 8;
    localparam int STICKY_LO = 1;
    localparam int STICKY_HI = 6;
    localparam logic [7:0] ECC_RESET = 8'h00;
    localparam logic [7:0] STICKY_MASK = 8'h7e;
    localparam int DIE_COUNT = 4;
    localparam int DIE_W = 2;
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_OP_DATA = 5'h10;
    // =========================================
    // Timing
    localparam int SYS_CLK_NS = 25;
    localparam int SCK_HALF_NS = 100;
    localparam int CS_GAP_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int CS_GAP_CYC = (CS_GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int TMR_W = 4;
    // =========================================
    // Host register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam logic [7:0] REG_INT_STATUS = 8'h0c;
    localparam logic [7:0] REG_INT_CLEAR = 8'h10;
    localparam logic [7:0] REG_INT_ENABLE = 8'h14;
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_START = 8;
    localparam int INT_DONE = 0;
    localparam int INT_REFUSED = 1;
    localparam int INT_W = 2;
    // Host command codes in CTRL[1:0]
    localparam logic [1:0] HCMD_UNLOCK = 2'h0;
    localparam logic [1:0] HCMD_WRITE = 2'h1;
    localparam logic [1:0] HCMD_READ = 2'h2;
    localparam logic [1:0] HCMD_CLEAR = 2'h3;
endpackage : ecr_pkg

// File: hw/ecr_link_if.sv
// Purpose: serial link between flash controller and flash device
// Assumes: serial output is pulled high when not driven
// Notes: the only place where the pin level is resolved
`timescale 1ns/100ps
interface ecr_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_out;
    logic so_oe_n;
    logic so;

    // Pull-up when the device releases the line
    assign so = so_oe_n ? 1'b1 : so_out;

    modport host (output cs_n, output sck, output si, input so);
    modport dev (input cs_n, input sck, input si, output so_out, output so_oe_n);
endinterface : ecr_link_if

// File: hw/ecr_sync.sv
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: inputs are independent levels
// Notes: only the second stage is visible to the caller
`timescale 1ns/100ps
module ecr_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // =========================================
    // Per-bit flop pair
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta;
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    meta <= INIT[g];
                    o_sync[g] <= INIT[g];
                end else begin
                    meta <= i_async[g];
                    o_sync[g] <= meta;
                end
            end
        end
    endgenerate
endmodule : ecr_sync

// File: hw/ecr_flash_host.sv
// Purpose: flash controller issuing ECC register commands
// Assumes: classic Wishbone slave, SPI mode 0 master
// Notes: one command per start; refused while busy
`timescale 1ns/100ps
module ecr_flash_host
    import ecr_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    ecr_link_if.host link,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq
);
    // =========================================
    // States
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_SHIFT = 3'b010,
        HS_GAP = 3'b100
    } ecr_host_state_t;

    ecr_host_state_t state;
    logic [TMR_W-1:0] tmr;
    logic [15:0] tx_sh;
    logic [7:0] rx_sh;
    logic [4:0] bit_cnt;
    logic [4:0] n_bits;
    logic [1:0] cmd;
    logic [7:0] txdata;
    logic [7:0] rxdata;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_enable;
    logic cs_n;
    logic sck;

    // =========================================
    // Wishbone decode
    wire wb_req = i_wb_cyc & i_wb_stb;
    wire wr_acc = wb_req & o_wb_ack & i_wb_we & i_wb_sel[0];
    wire wr_ctrl = wr_acc & (i_wb_adr == REG_CTRL);
    wire start = wr_ctrl & i_wb_dat[CTRL_START];
    wire busy = (state != HS_IDLE);
    wire launch = start & ~busy;
    wire refused = start & busy;
    wire wr_tx = wr_acc & (i_wb_adr == REG_TXDATA);
    wire wr_clr = wr_acc & (i_wb_adr == REG_INT_CLEAR);
    wire wr_en = wr_acc & (i_wb_adr == REG_INT_ENABLE);
    wire [1:0] new_cmd = i_wb_dat[CTRL_CMD_LSB+1:CTRL_CMD_LSB];
    wire [7:0] new_op = (new_cmd == HCMD_UNLOCK) ? OP_WRITE_UNLOCK :
                        (new_cmd == HCMD_WRITE) ? OP_ECC_WRITE :
                        (new_cmd == HCMD_READ) ? OP_ECC_READ : OP_ECC_CLEAR;
    wire has_byte = (new_cmd == HCMD_WRITE) | (new_cmd == HCMD_READ);
    wire [31:0] rd_mux = (i_wb_adr == REG_CTRL) ? {23'h0, busy, 6'h0, cmd} :
                         (i_wb_adr == REG_TXDATA) ? {24'h0, txdata} :
                         (i_wb_adr == REG_RXDATA) ? {24'h0, rxdata} :
                         (i_wb_adr == REG_INT_STATUS) ? {30'h0, int_status} :
                         (i_wb_adr == REG_INT_ENABLE) ? {30'h0, int_enable} : 32'h0;
    wire tmr_end = (tmr == TMR_W'(SCK_HALF_CYC - 1));
    wire gap_end = (tmr == TMR_W'(CS_GAP_CYC - 1));
    wire last_fall = tmr_end & sck & (bit_cnt == n_bits);
    wire done = (state == HS_GAP) & gap_end;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_req & ~o_wb_ack;
            o_wb_dat <= rd_mux;
        end
    end

    // =========================================
    // Serial engine
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= HS_IDLE;
            tmr <= '0;
            cs_n <= 1'b1;
            sck <= 1'b0;
            tx_sh <= 16'h0;
            rx_sh <= 8'h0;
            bit_cnt <= 5'h0;
            n_bits <= BITS_OPCODE;
            cmd <= HCMD_UNLOCK;
        end else begin
            unique case (state)
                HS_IDLE: begin
                    if (launch) begin
                        state <= HS_SHIFT;
                        cs_n <= 1'b0;
                        tmr <= '0;
                        bit_cnt <= 5'h0;
                        cmd <= new_cmd;
                        // Data byte follows the opcode directly
                        tx_sh <= {new_op, txdata};
                        n_bits <= has_byte ? BITS_OP_DATA : BITS_OPCODE;
                    end
                end
                HS_SHIFT: begin
                    tmr <= tmr_end ? '0 : tmr + TMR_W'(1);
                    if (last_fall) begin
                        // Select rises only after the last bit
                        state <= HS_GAP;
                        sck <= 1'b0;
                        cs_n <= 1'b1;
                    end else if (tmr_end) begin
                        sck <= ~sck;
                        if (!sck) begin
                            // Device samples on this rise
                            rx_sh <= {rx_sh[6:0], link.so};
                            bit_cnt <= bit_cnt + 5'h01;
                        end else begin
                            tx_sh <= {tx_sh[14:0], 1'b0};
                        end
                    end
                end
                HS_GAP: begin
                    tmr <= gap_end ? '0 : tmr + TMR_W'(1);
                    if (gap_end) begin
                        state <= HS_IDLE;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n;
    assign link.sck = sck;
    assign link.si = tx_sh[15];

    // =========================================
    // Registers and interrupt
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            txdata <= 8'h0;
            rxdata <= 8'h0;
            int_enable <= '0;
            int_status <= '0;
        end else begin
            if (wr_tx) begin
                txdata <= i_wb_dat[7:0];
            end
            if (done && cmd == HCMD_READ) begin
                rxdata <= rx_sh;
            end
            if (wr_en) begin
                int_enable <= i_wb_dat[INT_W-1:0];
            end
            // Set wins over a clear in the same cycle
            int_status <= (int_status & ~(wr_clr ? i_wb_dat[INT_W-1:0] : '0))
                        | {refused, done};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(int_status & int_enable);
        end
    end
endmodule : ecr_flash_host

// File: verification/ecr_link_chk.sv
// Purpose: protocol checks on the serial link between controller and device
// Assumes: mode 0 host, one system clock, synchronous reset
// Notes: instantiated beside the link interface, no bind
`timescale 1ns/100ps
module ecr_link_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_out,
    input wire logic so_oe_n,
    input wire logic so
);
    // =========================================
    // Helper: serial clock rises counted per frame
    logic sck_d;
    logic [4:0] rise_cnt;
    always_ff @(posedge i_sys_clk) begin
        sck_d <= sck;
        if (i_rst || cs_n) begin
            rise_cnt <= 5'h00;
        end else if (sck && !sck_d) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // =========================================
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock high outside a frame");
    a_si_hold_rise: assert property (!cs_n && $rose(sck) |-> $stable(si))
        else $error("serial input moved at a clock rise");
    a_sck_half_period: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
        else $error("serial clock high phase not four cycles");
    a_frame_starts_low: assert property ($fell(cs_n) |-> !sck)
        else $error("frame opened with serial clock high");
    a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n[*4])
        else $error("frames closer than four cycles");
    a_frame_whole_bytes: assert property ($rose(cs_n) |->
        rise_cnt == 5'h08 || rise_cnt == 5'h10)
        else $error("frame closed off a byte boundary");
    a_opcode_no_drive: assert property (!cs_n && rise_cnt < 5'h08 |-> so_oe_n)
        else $error("device drove output during opcode");
    a_so_released: assert property (cs_n [*4] |-> so_oe_n)
        else $error("device kept output driven after deselect");

    c_short_frame: cover property ($rose(cs_n) && rise_cnt == 5'h08);
    c_long_frame: cover property ($rose(cs_n) && rise_cnt == 5'h10);
    c_dev_drives: cover property (!cs_n && !so_oe_n);
endmodule : ecr_link_chk

// File: verification/test_ecc_register_commands.sv
// Purpose: end-to-end test of controller and device over the serial link
// Assumes: Wishbone classic access, done interrupt enabled unless masked
// Notes: device side events and die select driven directly by the bench
`timescale 1ns/100ps
module test_ecc_register_commands
    import ecr_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic sel_v = 1'b0, evt_v = 1'b0;
    logic [DIE_W-1:0] sel_die = 2'h0, evt_die = 2'h0, cur_die;
    logic [STICKY_HI:STICKY_LO] evt_bits = 6'h00;
    logic wlatch;
    logic [ECC_W-1:0] ecc;
    int error_cnt = 0;
    int cmp_count = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    // =========================================
    // Both ends joined by the link
    ecr_link_if ecr_link_if_i ();
    ecr_flash_dev ecr_flash_dev_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(ecr_link_if_i),
        .i_sel_valid(sel_v), .i_sel_die(sel_die), .i_evt_valid(evt_v), .i_evt_die(evt_die),
        .i_evt_bits(evt_bits), .o_sel_die(cur_die), .o_write_latch(wlatch), .o_ecc_reg(ecc));
    ecr_flash_host ecr_flash_host_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(ecr_link_if_i),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq));
    ecr_link_chk chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .cs_n(ecr_link_if_i.cs_n),
        .sck(ecr_link_if_i.sck), .si(ecr_link_if_i.si), .so_out(ecr_link_if_i.so_out),
        .so_oe_n(ecr_link_if_i.so_oe_n), .so(ecr_link_if_i.so));

    // =========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1, "no acknowledge");
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rd_chk

    // Starts one command, waits for done, checks and clears the interrupt
    task automatic run_cmd(input logic [1:0] c, input logic irq_exp);
        int n;
        n = 0;
        wb(1'b1, REG_CTRL, 32'h100 | 32'(c));
        do begin
            wb(1'b0, REG_INT_STATUS, 32'h0);
            n++;
        end while (rd[INT_DONE] !== 1'b1 && n < 200);
        chk(32'(rd[INT_DONE]), 32'h1, "done within poll limit");
        chk(32'(irq), 32'(irq_exp), "irq while done");
        wb(1'b1, REG_INT_CLEAR, 32'h3);
        rd_chk(REG_INT_STATUS, 32'h0, "status after clear");
        chk(32'(irq), 32'h0, "irq after clear");
    endtask : run_cmd

    task automatic wr_ecc(input logic [7:0] d);
        wb(1'b1, REG_TXDATA, 32'(d));
        run_cmd(HCMD_UNLOCK, 1'b1);
        chk(32'(wlatch), 32'h1, "latch after unlock");
        run_cmd(HCMD_WRITE, 1'b1);
        chk(32'(wlatch), 32'h0, "latch after write");
    endtask : wr_ecc

    task automatic event_in(input logic [1:0] die, input logic [5:0] bits);
        @(posedge i_sys_clk);
        evt_v <= 1'b1;
        evt_die <= die;
        evt_bits <= bits;
        @(posedge i_sys_clk);
        evt_v <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
    endtask : event_in

    task automatic tend(input string name);
        $display("test %s finished, errors so far %0d", name, error_cnt);
    endtask : tend

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // =========================================
    // Watchdog sized well above the expected run
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        error_cnt++;
        $display("unexpected at %0t: run timed out", $time);
        final_report();
    end

    // =========================================
    // Test sequence
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        chk(32'(ecc), 32'(ECC_RESET), "ecc reset");
        chk(32'(wlatch), 32'h0, "latch reset");
        rd_chk(8'h3c, 32'h0, "unmapped read");
        rd_chk(REG_INT_STATUS, 32'h0, "status reset");
        wb(1'b1, REG_INT_ENABLE, 32'h3);
        rd_chk(REG_INT_ENABLE, 32'h3, "enable readback");
        tend("reset");

        wb(1'b1, REG_TXDATA, 32'ha5);
        rd_chk(REG_TXDATA, 32'ha5, "tx data readback");
        run_cmd(HCMD_WRITE, 1'b1);
        chk(32'(ecc), 32'h00, "write without unlock");
        tend("locked write");

        wr_ecc(8'h81);
        chk(32'(ecc), 32'h81, "write applied");
        event_in(2'h0, 6'h15);
        chk(32'(ecc), 32'hab, "event sets sticky bits");
        wr_ecc(8'h00);
        chk(32'(ecc), 32'h2a, "sticky bits survive write");
        wr_ecc(8'h81);
        run_cmd(HCMD_READ, 1'b1);
        rd_chk(REG_RXDATA, 32'hab, "read back");
        tend("write and read");

        run_cmd(HCMD_CLEAR, 1'b1);
        chk(32'(ecc), 32'h81, "clear zeroes bits 6 to 1");
        run_cmd(HCMD_READ, 1'b1);
        rd_chk(REG_RXDATA, 32'h81, "read after clear");
        tend("clear");

        event_in(2'h2, 6'h01);
        chk(32'(ecc), 32'h81, "other die untouched");
        @(posedge i_sys_clk);
        sel_v <= 1'b1;
        sel_die <= 2'h2;
        @(posedge i_sys_clk);
        sel_v <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        chk(32'(cur_die), 32'h2, "die selected");
        run_cmd(HCMD_READ, 1'b1);
        rd_chk(REG_RXDATA, 32'h02, "read of selected die");
        tend("die select");

        wb(1'b1, REG_CTRL, 32'h100);
        wb(1'b1, REG_CTRL, 32'h100);
        rd_chk(REG_INT_STATUS, 32'h2, "start while busy flagged");
        rd_chk(REG_CTRL, 32'h100, "busy while shifting");
        run_cmd(HCMD_UNLOCK, 1'b1);
        wb(1'b1, REG_INT_ENABLE, 32'h0);
        run_cmd(HCMD_CLEAR, 1'b0);
        chk(32'(ecc), 32'h00, "clear on selected die");
        tend("refused start and mask");
        final_report();
    end
endmodule : test_ecc_register_commands
